// [include/dpg_pkg.sv]
// Package: register map, reset values and pin roles of the dual port pin mux
package dpg_pkg;

  localparam int P0_W = 8;
  localparam int P1_W = 4;
  localparam int SFR_W = 8;
  localparam int ROUTE_W = 2;

  // Register offsets on the special function register bus
  localparam logic [SFR_W-1:0] ADDR_PORT0_DATA  = 8'h80;
  localparam logic [SFR_W-1:0] ADDR_PORT1_DATA  = 8'h90;
  localparam logic [SFR_W-1:0] ADDR_P0_DRIVE    = 8'h93;
  localparam logic [SFR_W-1:0] ADDR_PORT0_DIRECTION      = 8'h94;
  localparam logic [SFR_W-1:0] ADDR_PORT0_ALT_SELECT      = 8'h95;
  localparam logic [SFR_W-1:0] ADDR_PORT1_DIRECTION      = 8'h96;
  localparam logic [SFR_W-1:0] ADDR_PORT1_ALT_SELECT      = 8'h97;
  localparam logic [SFR_W-1:0] ADDR_SPI_ROUTE   = 8'hb3;

  // Reset values
  localparam logic [P0_W-1:0]    RST_P0_DATA    = 8'hff;
  localparam logic [P0_W-1:0]    RST_P0_DRIVE   = 8'h00;
  localparam logic [P0_W-1:0]    RST_PORT0_DIRECTION     = 8'hff;
  localparam logic [P0_W-1:0]    RST_PORT0_ALT_SELECT     = 8'h00;
  localparam logic [P1_W-1:0]    RST_P1_DATA    = 4'hf;
  localparam logic [P1_W-1:0]    RST_PORT1_DIRECTION     = 4'h4;
  localparam logic [P1_W-1:0]    RST_PORT1_ALT_SELECT     = 4'h0;
  localparam logic [ROUTE_W-1:0] RST_SPI_ROUTE  = 2'h1;
  localparam logic [P1_W-1:0]    RST_P1_OE      = 4'hb;
  localparam logic [SFR_W-1:0]   RDATA_NONE     = 8'h00;

  // Route codes; the upper bit alone selects the internal radio path
  localparam logic [ROUTE_W-1:0] ROUTE_PORT1    = 2'h1;

  // Port 0 bit roles
  localparam int P0_GENERAL_TIMER_OUT = 0;
  localparam int P0_RXD    = 1;
  localparam int P0_TXD    = 2;
  localparam int P0_IRQ0   = 3;
  localparam int P0_IRQ1   = 4;
  localparam int P0_T0     = 5;
  localparam int P0_T1     = 6;
  localparam int P0_PWM    = 7;

  // Alternate functions that drive their pin
  localparam logic [P0_W-1:0] PORT0_ALT_SELECT_OUT_MASK = 8'h85;
  // Odd bits source, even bits sink under high drive
  localparam logic [P0_W-1:0] P0_ODD_MASK     = 8'haa;

  // Port 1 bit roles
  localparam int P1_SCK     = 0;
  localparam int P1_MOSI    = 1;
  localparam int P1_MISO    = 2;
  localparam int P1_BOOTSEL = 3;

  // Alternate count inputs are sampled once in this many clocks
  localparam int SAMPLE_PERIOD = 4;

  typedef struct packed {
    logic [SFR_W-1:0] addr;
    logic             wr;
    logic             rd;
    logic [SFR_W-1:0] wdata;
  } dpg_sfr_req_t;

endpackage : dpg_pkg

// [src/dpg_sync.sv]
// Two-stage synchroniser for a group of pin inputs
`timescale 1ns/100ps
module dpg_sync #(
  parameter int WIDTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);
  logic [WIDTH-1:0] stage1;

  // Stage one feeds stage two and nothing else; pins idle high
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      stage1   <= '1;
      sync_out <= '1;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

  if (WIDTH < 1) begin : g_bad_width
    $error("dpg_sync needs WIDTH of at least one");
  end
endmodule : dpg_sync

// [src/dpg_top.sv]
// Pin control for port 0 and port 1 with alternate function routing
//
// Function
// - Port 0 alternate select outranks direction bit
// - Alternate function fixes port 0 pin direction
// - Receive pin direction follows direction bit one
// - External interrupts pass only when alternate selected
// - Timer0/1 count inputs sampled every four clocks
// - Without alternate, direction bit picks in/out
// - Port 0 resets input, latch ones, cleared
// - High drive: odd bits source, even sink
// - Route 01 makes port 1 SPI master
// - Route 01 overrides port 1 direction bits
// - Otherwise alternate bit0 makes SCK timer2 input
// - Without SPI, MOSI is plain I/O
// - MISO pin is always an input
// - Port 1 bits 1,3 ignore alternate bits
// - Boot memory select is forced to drive its latch bit under route 01, otherwise plain I/O
// - Port 1 registers four bits, reset F/4/0
// - Route code 00 unused, 01 port1, 1x radio
// - Reset holds port 0 input, port 1 SPI
`timescale 1ns/100ps
module dpg_top
  import dpg_pkg::*;
#(
  parameter int SAMPLE_CYCLES = dpg_pkg::SAMPLE_PERIOD
) (
  input  wire logic                          core_clk,
  input  wire logic                          arst_n,
  input  wire dpg_pkg::dpg_sfr_req_t         sfr,
  output logic      [dpg_pkg::SFR_W-1:0]     sfr_rdata,
  input  wire logic [dpg_pkg::P0_W-1:0]      p0_in,
  output logic      [dpg_pkg::P0_W-1:0]      p0_out,
  output logic      [dpg_pkg::P0_W-1:0]      p0_oe,
  output logic      [dpg_pkg::P0_W-1:0]      p0_src_hi,
  output logic      [dpg_pkg::P0_W-1:0]      p0_sink_hi,
  input  wire logic [dpg_pkg::P1_W-1:0]      p1_in,
  output logic      [dpg_pkg::P1_W-1:0]      p1_out,
  output logic      [dpg_pkg::P1_W-1:0]      p1_oe,
  output logic      [dpg_pkg::ROUTE_W-1:0]   spi_route_select,
  input  wire logic                          spi_sck_drive,
  input  wire logic                          spi_mosi_drive,
  output logic                               spi_miso,
  input  wire logic                          general_timer_out,
  input  wire logic                          uart_txd,
  input  wire logic                          uart_rxd_out,
  output logic                               uart_rxd_in,
  input  wire logic                          pwm_out,
  output logic                               ext_irq0_n,
  output logic                               ext_irq1_n,
  output logic                               timer0_count_in,
  output logic                               timer1_count_in,
  output logic                               timer2_count_in
);
  import dpg_pkg::*;

  localparam int CNT_W = (SAMPLE_CYCLES > 1) ? $clog2(SAMPLE_CYCLES) : 1;
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  // Alternate functions that only listen on their pin; receive is excluded as its direction is a choice
  localparam logic [P0_W-1:0] ALT_IN_MASK = ~PORT0_ALT_SELECT_OUT_MASK & ~(P0_W'(1) << P0_RXD);

  if (SAMPLE_CYCLES < 2) begin : g_bad_period
    $error("dpg_top needs SAMPLE_CYCLES of at least two");
  end

  // True when a port 0 bit drives its pin
  function automatic logic p0_drives(input logic alt, input logic dir, input int idx);
    logic drv;
    drv = !dir;
    if (alt) begin
      if (idx == P0_RXD) drv = !dir;
      else drv = PORT0_ALT_SELECT_OUT_MASK[idx];
    end
    return drv;
  endfunction : p0_drives

  // Write strobe decode for one register
  function automatic logic wr_hit(input dpg_sfr_req_t req, input logic [SFR_W-1:0] addr);
    return req.wr && (req.addr == addr);
  endfunction : wr_hit

  logic [P0_W-1:0]    port0_data;
  logic [P0_W-1:0]    port0_drive_strength;
  logic [P0_W-1:0]    port0_direction;
  logic [P0_W-1:0]    port0_alt_select;
  logic [P1_W-1:0]    port1_data;
  logic [P1_W-1:0]    port1_direction;
  logic [P1_W-1:0]    port1_alt_select;
  logic [P0_W-1:0]    p0_pin;
  logic [P1_W-1:0]    p1_pin;
  logic [P0_W-1:0]    next_p0_out;
  logic [P0_W-1:0]    next_p0_oe;
  logic [P1_W-1:0]    next_p1_out;
  logic [P1_W-1:0]    next_p1_oe;
  logic [P0_W-1:0]    port0_alt_select_value;
  logic [CNT_W-1:0]   sample_cnt;
  logic               sample_tick;
  logic               spi_mode;

  // Every pin input crosses two flops before anything reads it
  dpg_sync #(.WIDTH(P0_W)) u_sync_p0 (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (p0_in),
    .sync_out (p0_pin)
  );

  dpg_sync #(.WIDTH(P1_W)) u_sync_p1 (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (p1_in),
    .sync_out (p1_pin)
  );

  // Port 0 output latch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port0_data <= RST_P0_DATA;
    end else if (wr_hit(sfr, ADDR_PORT0_DATA)) begin
      port0_data <= sfr.wdata;
    end
  end

  // Port 0 configuration
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port0_drive_strength <= RST_P0_DRIVE;
      port0_direction      <= RST_PORT0_DIRECTION;
      port0_alt_select     <= RST_PORT0_ALT_SELECT;
    end else begin
      if (wr_hit(sfr, ADDR_P0_DRIVE)) port0_drive_strength <= sfr.wdata;
      if (wr_hit(sfr, ADDR_PORT0_DIRECTION)) port0_direction <= sfr.wdata;
      if (wr_hit(sfr, ADDR_PORT0_ALT_SELECT)) port0_alt_select <= sfr.wdata;
    end
  end

  // Port 1 keeps only its low four bits; upper write data is dropped
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      port1_data       <= RST_P1_DATA;
      port1_direction  <= RST_PORT1_DIRECTION;
      port1_alt_select <= RST_PORT1_ALT_SELECT;
    end else begin
      if (wr_hit(sfr, ADDR_PORT1_DATA)) port1_data <= sfr.wdata[P1_W-1:0];
      if (wr_hit(sfr, ADDR_PORT1_DIRECTION)) port1_direction <= sfr.wdata[P1_W-1:0];
      if (wr_hit(sfr, ADDR_PORT1_ALT_SELECT)) port1_alt_select <= sfr.wdata[P1_W-1:0];
    end
  end

  // Route defaults to port 1 so the boot loader finds its SPI pins
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      spi_route_select <= RST_SPI_ROUTE;
    end else if (wr_hit(sfr, ADDR_SPI_ROUTE)) begin
      spi_route_select <= sfr.wdata[ROUTE_W-1:0];
    end
  end

  assign spi_mode = (spi_route_select == ROUTE_PORT1);

  // Read data; data registers return pin levels, not the latch
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sfr_rdata <= RDATA_NONE;
    end else if (sfr.rd) begin
      unique case (sfr.addr)
        ADDR_PORT0_DATA: sfr_rdata <= p0_pin;
        ADDR_PORT1_DATA: sfr_rdata <= {{(SFR_W-P1_W){1'b0}}, p1_pin};
        ADDR_P0_DRIVE:   sfr_rdata <= port0_drive_strength;
        ADDR_PORT0_DIRECTION:     sfr_rdata <= port0_direction;
        ADDR_PORT0_ALT_SELECT:     sfr_rdata <= port0_alt_select;
        ADDR_PORT1_DIRECTION:     sfr_rdata <= {{(SFR_W-P1_W){1'b0}}, port1_direction};
        ADDR_PORT1_ALT_SELECT:     sfr_rdata <= {{(SFR_W-P1_W){1'b0}}, port1_alt_select};
        ADDR_SPI_ROUTE:  sfr_rdata <= {{(SFR_W-ROUTE_W){1'b0}}, spi_route_select};
        default:         sfr_rdata <= RDATA_NONE;
      endcase
    end
  end

  // Values that alternate outputs put on port 0; inputs leave ones
  always_comb begin
    port0_alt_select_value           = '1;
    port0_alt_select_value[P0_GENERAL_TIMER_OUT] = general_timer_out;
    port0_alt_select_value[P0_RXD]    = uart_rxd_out;
    port0_alt_select_value[P0_TXD]    = uart_txd;
    port0_alt_select_value[P0_PWM]    = pwm_out;
  end

  for (genvar i = 0; i < P0_W; i++) begin : g_p0_bit
    assign next_p0_oe[i]  = p0_drives(port0_alt_select[i], port0_direction[i], i);
    assign next_p0_out[i] = port0_alt_select[i] ? port0_alt_select_value[i] : port0_data[i];
  end

  // Port 1 pin roles under the SPI route
  always_comb begin
    next_p1_oe  = ~port1_direction;
    next_p1_out = port1_data;
    if (spi_mode) begin
      next_p1_oe[P1_SCK]     = 1'b1;
      next_p1_oe[P1_MOSI]    = 1'b1;
      next_p1_oe[P1_BOOTSEL] = 1'b1;
      next_p1_out[P1_SCK]    = spi_sck_drive;
      next_p1_out[P1_MOSI]   = spi_mosi_drive;
    end else if (port1_alt_select[P1_SCK]) begin
      next_p1_oe[P1_SCK] = 1'b0;
    end
    // MOSI and the boot select bit keep direction bits otherwise
    next_p1_oe[P1_MISO] = 1'b0;
  end

  // Pin drivers are registered so the pads see no decode glitches
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      p0_out <= RST_P0_DATA;
      p0_oe  <= '0;
      p1_out <= RST_P1_DATA;
      p1_oe  <= RST_P1_OE;
    end else begin
      p0_out <= next_p0_out;
      p0_oe  <= next_p0_oe;
      p1_out <= next_p1_out;
      p1_oe  <= next_p1_oe;
    end
  end

  // High drive split by bit parity
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      p0_src_hi  <= '0;
      p0_sink_hi <= '0;
    end else begin
      p0_src_hi  <= port0_drive_strength & P0_ODD_MASK;
      p0_sink_hi <= port0_drive_strength & ~P0_ODD_MASK;
    end
  end

  // Interrupt and serial inputs; idle high when not selected
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      ext_irq0_n  <= 1'b1;
      ext_irq1_n  <= 1'b1;
      uart_rxd_in <= 1'b1;
      spi_miso    <= 1'b1;
    end else begin
      ext_irq0_n  <= port0_alt_select[P0_IRQ0] ? p0_pin[P0_IRQ0] : 1'b1;
      ext_irq1_n  <= port0_alt_select[P0_IRQ1] ? p0_pin[P0_IRQ1] : 1'b1;
      uart_rxd_in <= (port0_alt_select[P0_RXD] && port0_direction[P0_RXD]) ? p0_pin[P0_RXD] : 1'b1;
      spi_miso    <= spi_mode ? p1_pin[P1_MISO] : 1'b1;
    end
  end

  // Count input sampling phase
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sample_cnt <= '0;
    end else if (sample_tick) begin
      sample_cnt <= '0;
    end else begin
      sample_cnt <= sample_cnt + 1'b1;
    end
  end

  assign sample_tick = (sample_cnt == CNT_LAST);

  // Slow sampling limits count input rate to a quarter of the clock
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      timer0_count_in <= 1'b0;
      timer1_count_in <= 1'b0;
      timer2_count_in <= 1'b0;
    end else if (sample_tick) begin
      timer0_count_in <= port0_alt_select[P0_T0] && p0_pin[P0_T0];
      timer1_count_in <= port0_alt_select[P0_T1] && p0_pin[P0_T1];
      timer2_count_in <= !spi_mode && port1_alt_select[P1_SCK] && p1_pin[P1_SCK];
    end
  end

  // Checks
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_p0_data_write;
    wr_hit(sfr, ADDR_PORT0_DATA) && port0_alt_select[P0_TXD] == 1'b0 && port0_direction[P0_TXD] == 1'b0;
  endsequence

  sequence s_plain_out_kept;
    port0_alt_select[P0_TXD] == 1'b0 && port0_direction[P0_TXD] == 1'b0;
  endsequence

  property p_alt_over_dir;
    port0_alt_select[P0_GENERAL_TIMER_OUT] |=> p0_oe[P0_GENERAL_TIMER_OUT];
  endproperty
  a_alt_over_dir: assert property (p_alt_over_dir) else $error("alt output not driving");

  property p_alt_input;
    (port0_alt_select & ALT_IN_MASK) != '0 |=> (p0_oe & $past(port0_alt_select) & ALT_IN_MASK) == '0;
  endproperty
  a_alt_input: assert property (p_alt_input) else $error("alt input pin driven");

  property p_rxd_dir;
    port0_alt_select[P0_RXD] |=> p0_oe[P0_RXD] == !$past(port0_direction[P0_RXD]);
  endproperty
  a_rxd_dir: assert property (p_rxd_dir) else $error("receive pin direction wrong");

  property p_irq_gate;
    !port0_alt_select[P0_IRQ1] |=> ext_irq1_n;
  endproperty
  a_irq_gate: assert property (p_irq_gate) else $error("interrupt passed while not selected");

  property p_sample_period;
    sample_tick |=> !sample_tick [*3] ##1 sample_tick;
  endproperty
  a_sample_period: assert property (p_sample_period) else $error("count sample period wrong");

  property p_count_changes_on_tick;
    $changed(timer0_count_in) |-> $past(sample_tick);
  endproperty
  a_count_changes_on_tick: assert property (p_count_changes_on_tick) else $error("count input off tick");

  property p_plain_write;
    s_p0_data_write ##1 s_plain_out_kept |=> p0_oe[P0_TXD] && p0_out[P0_TXD] == $past(sfr.wdata[P0_TXD], 2);
  endproperty
  a_plain_write: assert property (p_plain_write) else $error("plain output not following latch");

  property p_drive_split;
    wr_hit(sfr, ADDR_P0_DRIVE) |=> ##1 p0_src_hi == ($past(sfr.wdata, 2) & P0_ODD_MASK);
  endproperty
  a_drive_split: assert property (p_drive_split) else $error("high source bits wrong");

  property p_spi_dirs;
    spi_mode |=> p1_oe[P1_SCK] && p1_oe[P1_MOSI] && p1_oe[P1_BOOTSEL];
  endproperty
  a_spi_dirs: assert property (p_spi_dirs) else $error("SPI pin directions wrong");

  property p_sck_timer_in;
    !spi_mode && port1_alt_select[P1_SCK] |=> !p1_oe[P1_SCK];
  endproperty
  a_sck_timer_in: assert property (p_sck_timer_in) else $error("SCK driven as timer input");

  property p_mosi_plain;
    !spi_mode |=> p1_oe[P1_MOSI] == !$past(port1_direction[P1_MOSI]);
  endproperty
  a_mosi_plain: assert property (p_mosi_plain) else $error("MOSI not following direction");

  property p_miso_in;
    !p1_oe[P1_MISO] [*2];
  endproperty
  a_miso_in: assert property (p_miso_in) else $error("MISO pin driven");

  property p_p1_upper_zero;
    sfr.rd && sfr.addr == ADDR_PORT1_DIRECTION |=> sfr_rdata[SFR_W-1:P1_W] == '0;
  endproperty
  a_p1_upper_zero: assert property (p_p1_upper_zero) else $error("port 1 upper bits not zero");

endmodule : dpg_top

// [dv/dpg_board_model.sv]
// Board model: pin pull-ups, external drivers and the boot memory select
`timescale 1ns/100ps
module dpg_board_model
  import dpg_pkg::*;
(
  input  wire logic [P0_W-1:0] p0_out,
  input  wire logic [P0_W-1:0] p0_oe,
  input  wire logic [P0_W-1:0] x0_en,
  input  wire logic [P0_W-1:0] x0_val,
  input  wire logic [P1_W-1:0] p1_out,
  input  wire logic [P1_W-1:0] p1_oe,
  input  wire logic [P1_W-1:0] x1_en,
  input  wire logic [P1_W-1:0] x1_val,
  output logic      [P0_W-1:0] p0_in,
  output logic      [P1_W-1:0] p1_in,
  output logic                 boot_cs_n
);
  // Pull-ups on every pin, so a released pin reads high rather than holding its last value
  assign p0_in = (p0_oe & p0_out) | (~p0_oe & x0_en & x0_val) | (~p0_oe & ~x0_en);
  assign p1_in = (p1_oe & p1_out) | (~p1_oe & x1_en & x1_val) | (~p1_oe & ~x1_en);
  // Boot memory chip select taken from port 1 bit 3 only
  assign boot_cs_n = p1_in[P1_BOOTSEL];
endmodule : dpg_board_model

// [dv/tb.sv]
// Self-checking bench for the dual port pin mux
`timescale 1ns/100ps
module tb;
  import dpg_pkg::*;
  logic               core_clk = 1'b0;
  logic               arst_n   = 1'b0;
  dpg_sfr_req_t       sfr      = '0;
  logic [SFR_W-1:0]   sfr_rdata;
  logic [P0_W-1:0]    p0_in, p0_out, p0_oe, p0_src, p0_sink;
  logic [P0_W-1:0]    x0_en = '0, x0_val = '0;
  logic [P1_W-1:0]    p1_in, p1_out, p1_oe;
  logic [P1_W-1:0]    x1_en = '0, x1_val = '0;
  logic [ROUTE_W-1:0] route;
  logic               sck = 1'b1, mosi = 1'b1, gto = 1'b0, txd = 1'b0, rxo = 1'b0, pwm = 1'b0;
  logic               miso, rxi, irq0_n, irq1_n, t0, t1, t2, boot_cs_n;
  logic               rd_q = 1'b0, rd_qq = 1'b0;
  logic [SFR_W-1:0]   exp_q[$];
  logic [31:0]        seed = 32'd89;
  logic [31:0]        v;
  int                 n_fail = 0, comparisons = 0, cycles = 0;
  logic [7:0]  ra[9] = '{8'h80, 8'h93, 8'h94, 8'h95, 8'h90, 8'h96, 8'h97, 8'hb3, 8'h81};
  logic [7:0]  re[9] = '{8'hff, 8'h00, 8'hff, 8'h00, 8'h0f, 8'h04, 8'h00, 8'h01, 8'h00};
  // Port 0 table: alt, dir, expected enables
  logic [23:0] t0tab[5] = '{24'h0000ff, 24'h00ff00, 24'hff0087, 24'hffff85, 24'hf00f80};
  // Port 1 table: route, dir, alt, expected enables
  logic [15:0] t1tab[4] = '{16'h000b, 16'h2f00, 16'h30fa, 16'h1ffb};

  dpg_top #(.SAMPLE_CYCLES(SAMPLE_PERIOD)) u_dut (
    .core_clk(core_clk), .arst_n(arst_n), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .p0_in(p0_in), .p0_out(p0_out), .p0_oe(p0_oe), .p0_src_hi(p0_src), .p0_sink_hi(p0_sink),
    .p1_in(p1_in), .p1_out(p1_out), .p1_oe(p1_oe), .spi_route_select(route),
    .spi_sck_drive(sck), .spi_mosi_drive(mosi), .spi_miso(miso), .general_timer_out(gto),
    .uart_txd(txd), .uart_rxd_out(rxo), .uart_rxd_in(rxi), .pwm_out(pwm), .ext_irq0_n(irq0_n),
    .ext_irq1_n(irq1_n), .timer0_count_in(t0), .timer1_count_in(t1), .timer2_count_in(t2)
  );

  dpg_board_model u_board (
    .p0_out(p0_out), .p0_oe(p0_oe), .x0_en(x0_en), .x0_val(x0_val), .p1_out(p1_out),
    .p1_oe(p1_oe), .x1_en(x1_en), .x1_val(x1_val), .p0_in(p0_in), .p1_in(p1_in),
    .boot_cs_n(boot_cs_n)
  );

  initial begin
    forever #10 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    sfr.addr  = a;
    sfr.wdata = d;
    sfr.wr    = 1'b1;
    @(negedge core_clk);
    sfr.wr = 1'b0;
  endtask : wr

  // The expected byte is noted when the read is issued; the monitor compares it
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(negedge core_clk);
    sfr.addr = a;
    sfr.rd   = 1'b1;
    exp_q.push_back(e);
    @(negedge core_clk);
    sfr.rd = 1'b0;
    @(negedge core_clk);
  endtask : rd

  // Covers register, synchroniser and output stage plus one sample period
  task automatic settle();
    repeat (10) @(negedge core_clk);
  endtask : settle

  always @(posedge core_clk) begin
    rd_q  <= sfr.rd;
    rd_qq <= rd_q;
    cycles++;
    if (cycles == 5000) begin
      n_fail++;
      report_and_stop();
    end
  end

  always @(negedge core_clk) begin
    if (rd_qq) begin
      check(sfr_rdata, exp_q.pop_front());
    end
  end

  initial begin
    repeat (20) @(negedge core_clk);
    check(p0_oe, 8'h00);
    check(p0_out, 8'hff);
    check(8'(p1_oe), 8'h0b);
    check(8'(route), 8'h01);
    arst_n = 1'b1;
    settle();
    check(8'(boot_cs_n), 8'h01);
    for (int i = 0; i < 9; i++) begin
      rd(ra[i], re[i]);
    end
    wr(ADDR_PORT1_DIRECTION, 8'hf3);
    rd(ADDR_PORT1_DIRECTION, 8'h03);
    wr(8'h81, 8'h12);
    rd(ADDR_PORT1_DIRECTION, 8'h03);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_PORT0_ALT_SELECT, t0tab[i][23:16]);
      wr(ADDR_PORT0_DIRECTION, t0tab[i][15:8]);
      settle();
      check(p0_oe, t0tab[i][7:0]);
    end
    wr(ADDR_PORT0_DIRECTION, 8'h00);
    wr(ADDR_PORT0_ALT_SELECT, 8'hff);
    v = xs();
    {pwm, txd, rxo, gto} = v[3:0];
    settle();
    check({4'h0, p0_out[7], p0_out[2:0]}, {4'h0, v[3:0]});
    wr(ADDR_PORT0_ALT_SELECT, 8'h00);
    v = xs();
    wr(ADDR_PORT0_DATA, v[7:0]);
    settle();
    check(p0_out, v[7:0]);
    rd(ADDR_PORT0_DATA, v[7:0]);
    wr(ADDR_P0_DRIVE, v[15:8]);
    settle();
    check(p0_src, v[15:8] & 8'haa);
    check(p0_sink, v[15:8] & 8'h55);
    wr(ADDR_PORT0_DIRECTION, 8'hff);
    x0_en = 8'hff;
    for (int k = 0; k < 2; k++) begin
      v = k ? ~v : xs();
      x0_val = v[7:0];
      wr(ADDR_PORT0_ALT_SELECT, 8'h7a);
      settle();
      rd(ADDR_PORT0_DATA, v[7:0]);
      check({5'h0, rxi, irq1_n, irq0_n}, {5'h0, v[1], v[4], v[3]});
      check({6'h0, t1, t0}, {6'h0, v[6:5]});
      wr(ADDR_PORT0_ALT_SELECT, 8'h00);
      settle();
      check({3'h0, rxi, irq1_n, irq0_n, t1, t0}, 8'h1c);
    end
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_PORT1_DIRECTION, {4'h0, t1tab[i][11:8]});
      wr(ADDR_PORT1_ALT_SELECT, {4'h0, t1tab[i][7:4]});
      wr(ADDR_SPI_ROUTE, {4'h0, t1tab[i][15:12]});
      settle();
      check(8'(p1_oe), {4'h0, t1tab[i][3:0]});
    end
    x1_en = 4'h5;
    x1_val = 4'h1;
    v = xs();
    {mosi, sck} = v[1:0];
    wr(ADDR_PORT1_DATA, 8'h00);
    settle();
    check({5'h0, miso, p1_out[1:0]}, {5'h0, 1'b0, v[1:0]});
    check({6'h0, boot_cs_n, t2}, 8'h00);
    x1_val = 4'h0;
    wr(ADDR_SPI_ROUTE, 8'h00);
    wr(ADDR_PORT1_ALT_SELECT, 8'h01);
    settle();
    check({6'h0, miso, t2}, 8'h02);
    x1_val = 4'h1;
    settle();
    check(8'(t2), 8'h01);
    settle();
    report_and_stop();
  end
endmodule : tb
